// ==== dcc_pkg.sv ====
// shared constants and types of the two-channel dma controller
package dcc_pkg;
   localparam int ADDR_W     = 20;
   localparam int DATA_W     = 16;
   localparam int CNT_W      = 16;
   localparam int FSEL_W     = 4;
   localparam int NPERIPH    = 14;
   // register byte offsets, channel one sits one stride above zero
   localparam logic [7:0] CH_STRIDE  = 8'h20;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_SRC    = 8'h04;
   localparam logic [7:0] OFF_DST    = 8'h08;
   localparam logic [7:0] OFF_RELOAD = 8'h0C;
   localparam logic [7:0] OFF_COUNT  = 8'h10;
   localparam logic [7:0] OFF_FWD    = 8'h14;
   localparam logic [7:0] OFF_CYCLES = 8'h18;
   localparam logic [7:0] OFF_CFG    = 8'h40;
   // control register fields
   localparam int CTRL_EN     = 0;
   localparam int CTRL_REQ    = 1;
   localparam int CTRL_UNIT   = 2;
   localparam int CTRL_DIR    = 3;
   localparam int CTRL_EDGE   = 4;
   localparam int CTRL_SWTRIG = 5;
   localparam int CTRL_FSEL   = 8;
   localparam logic [FSEL_W-1:0] FSEL_SOFT = 4'h0;
   localparam logic [FSEL_W-1:0] FSEL_EXT  = 4'hF;
   // configuration register fields
   localparam int CFG_INT_WAIT = 0;
   localparam int CFG_EXT_WAIT = 1;
   localparam int CFG_MUX      = 2;
   localparam logic [2:0] CFG_RESET = 3'h0;
   // address areas
   localparam logic [ADDR_W-1:0] PERIPH_LIMIT = 20'h00400;
   localparam logic [ADDR_W-1:0] INT_LIMIT    = 20'h0C000;
   // bus cycles per access, and accesses per transfer unit
   localparam logic [1:0] COEF_FAST = 2'h1;
   localparam logic [1:0] COEF_WAIT = 2'h2;
   localparam logic [1:0] COEF_MUX  = 2'h3;
   localparam logic [1:0] BEATS_ONE = 2'h1;
   localparam logic [1:0] BEATS_TWO = 2'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              we;
      logic              byte_sz;
      logic [DATA_W-1:0] wdata;
   } dcc_mem_req_t;
endpackage

// ==== dcc_buf2.sv ====
// small valid/ready buffer between the read and write phases
`timescale 1ns/1ns
module dcc_buf2 #(
   parameter int W     = 16,
   parameter int DEPTH = 2
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wp;
   logic [PW-1:0] rp;
   logic [PW:0]   fill;
   logic          push;
   logic          pop;

   // full only when every entry holds a word, fill is one bit wider
   assign in_ready_o  = (fill != (PW+1)'(DEPTH));
   assign out_valid_o = (fill != '0);
   assign out_data_o  = mem[rp];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wp] <= in_data_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wp   <= '0;
         rp   <= '0;
         fill <= '0;
      end
      else
      begin
         if (push)
            wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
         if (pop)
            rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
         fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

// ==== dcc_dma_ctrl.sv ====
// two-channel dma controller with wishbone register access
// Summary of operation
// - cycles per unit equal reads times j plus writes times k
// - any address parity; word units split in two on odd or byte bus
// - writing one to enable makes the channel active
// - first transfer loads forward pointer from the forward-designated pointer
// - first transfer loads the counter from its reload register
// - rewriting enable restarts the channel, repeating both reloads
// - each channel takes requests from one selected factor
// - request bit sets on its factor regardless of enable
// - request bit clears just before the channel's transfer starts
// - software writing zero clears the request bit; one does nothing
// - peripheral factors set the request with the peripheral's own flag
// - external pin factor sets the request on the selected pin edge
// - simultaneous requests set together; channel zero transfers first
// - after each channel transfer the cpu gets one bus access
// - controller accesses use the width chosen by the bus-width pin
`timescale 1ns/1ns
module dcc_dma_ctrl
   import dcc_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic [31:0]             wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic [NPERIPH-1:0] periph_irq_i,
   input  wire logic [1:0]         external_request_pin_i,
   input  wire logic               byte_bus_pin_i,
   output logic                    bus_req_o,
   input  wire logic               bus_grant_i,
   input  wire logic               cpu_done_i,
   output dcc_mem_req_t            mem_req_o,
   output logic                    mem_valid_o,
   input  wire logic               mem_ack_i,
   input  wire logic [DATA_W-1:0]  mem_rdata_i
);
   typedef enum {S_IDLE, S_RD, S_WR, S_CPU} dcc_state_t;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (old & ~m) | (d & m);
   endfunction

   function automatic logic [1:0] coef(input logic [ADDR_W-1:0] a,
                                       input logic [2:0] c);
      if (a < PERIPH_LIMIT)
         return COEF_WAIT;
      if (a < INT_LIMIT)
         return c[CFG_INT_WAIT] ? COEF_WAIT : COEF_FAST;
      if (c[CFG_MUX])
         return COEF_MUX;
      return c[CFG_EXT_WAIT] ? COEF_WAIT : COEF_FAST;
   endfunction

   function automatic logic [1:0] beats(input logic unit_byte,
                                        input logic byte_bus,
                                        input logic odd);
      return (!unit_byte && (byte_bus || odd)) ? BEATS_TWO : BEATS_ONE;
   endfunction

   logic [31:0]       ctrl [2];
   logic [ADDR_W-1:0] src [2];
   logic [ADDR_W-1:0] dst [2];
   logic [CNT_W-1:0]  reload [2];
   logic [CNT_W-1:0]  count [2];
   logic [ADDR_W-1:0] fwd [2];
   logic [7:0]        cycles [2];
   logic [1:0]        en;
   logic [1:0]        req;
   logic [1:0]        first;
   logic [1:0]        trig;
   logic [1:0]        ctrl_wr;
   logic [2:0]        cfg;
   logic              wb_hit;
   logic              wb_wr;
   logic [31:0]       rd_val;
   logic [1:0]        ext_s1;
   logic [1:0]        ext_s2;
   logic [1:0]        ext_s3;
   logic              bb_s1;
   logic              byte_bus;
   dcc_state_t        state;
   logic              cur;
   logic              pick;
   logic              pick_any;
   logic              start;
   logic              finish;
   logic [ADDR_W-1:0] rd_base;
   logic [ADDR_W-1:0] wr_base;
   logic [ADDR_W-1:0] fwd_lat;
   logic [CNT_W-1:0]  cnt_lat;
   logic              unit_byte;
   logic              dir_lat;
   logic [1:0]        rd_n;
   logic [1:0]        wr_n;
   logic              beat;
   logic [7:0]        lo_byte;
   logic              buf_in_valid;
   logic              buf_in_ready;
   logic              buf_out_valid;
   logic [DATA_W-1:0] buf_in_data;
   logic [DATA_W-1:0] buf_out_data;
   logic              last_beat;
   logic              issue;
   logic [ADDR_W-1:0] fwd_base [2];

   // ---------------- wishbone slave, one wait state
   assign wb_hit = wb_cyc_i & wb_stb_i & !wb_ack_o;
   assign wb_wr  = wb_hit & wb_we_i;

   always_comb
   begin
      rd_val = 32'h0000_0000;
      for (int c = 0; c < 2; c++)
      begin
         ctrl_wr[c] = wb_wr && wb_adr_i == OFF_CTRL + 8'(c) * CH_STRIDE;
         if (wb_adr_i == OFF_CTRL + 8'(c) * CH_STRIDE)
            rd_val = {ctrl[c][31:2], req[c], en[c]};
         if (wb_adr_i == OFF_SRC + 8'(c) * CH_STRIDE)
            rd_val = 32'(src[c]);
         if (wb_adr_i == OFF_DST + 8'(c) * CH_STRIDE)
            rd_val = 32'(dst[c]);
         if (wb_adr_i == OFF_RELOAD + 8'(c) * CH_STRIDE)
            rd_val = 32'(reload[c]);
         if (wb_adr_i == OFF_COUNT + 8'(c) * CH_STRIDE)
            rd_val = 32'(count[c]);
         if (wb_adr_i == OFF_FWD + 8'(c) * CH_STRIDE)
            rd_val = 32'(fwd[c]);
         if (wb_adr_i == OFF_CYCLES + 8'(c) * CH_STRIDE)
            rd_val = 32'(cycles[c]);
      end
      if (wb_adr_i == OFF_CFG)
         rd_val = 32'(cfg);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wb_hit;
         if (wb_hit && !wb_we_i)
            wb_dat_o <= rd_val;
      end
   end

   // plain software-owned registers, one set per channel plus the shared cfg
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg <= CFG_RESET;
         for (int c = 0; c < 2; c++)
         begin
            ctrl[c]   <= 32'h0000_0000;
            src[c]    <= '0;
            dst[c]    <= '0;
            reload[c] <= '0;
         end
      end
      else if (wb_wr)
      begin
         if (wb_adr_i == OFF_CFG)
            cfg <= 3'(merge(32'(cfg), wb_dat_i, wb_sel_i));
         for (int c = 0; c < 2; c++)
         begin
            if (ctrl_wr[c])
               ctrl[c] <= merge(ctrl[c], wb_dat_i, wb_sel_i);
            if (wb_adr_i == OFF_SRC + 8'(c) * CH_STRIDE)
               src[c] <= ADDR_W'(merge(32'(src[c]), wb_dat_i, wb_sel_i));
            if (wb_adr_i == OFF_DST + 8'(c) * CH_STRIDE)
               dst[c] <= ADDR_W'(merge(32'(dst[c]), wb_dat_i, wb_sel_i));
            if (wb_adr_i == OFF_RELOAD + 8'(c) * CH_STRIDE)
               reload[c] <= CNT_W'(merge(32'(reload[c]), wb_dat_i,
                                         wb_sel_i));
         end
      end
   end

   // ---------------- pin synchronisers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ext_s1   <= 2'h0;
         ext_s2   <= 2'h0;
         ext_s3   <= 2'h0;
         bb_s1    <= 1'b0;
         byte_bus <= 1'b0;
      end
      else
      begin
         ext_s1   <= external_request_pin_i;
         ext_s2   <= ext_s1;
         ext_s3   <= ext_s2;
         bb_s1    <= byte_bus_pin_i;
         byte_bus <= bb_s1;
      end
   end

   // ---------------- request factors
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         logic [FSEL_W-1:0] f;
         f = ctrl[c][CTRL_FSEL +: FSEL_W];
         if (f == FSEL_SOFT)
            trig[c] = ctrl_wr[c] & wb_sel_i[0] & wb_dat_i[CTRL_SWTRIG];
         else if (f == FSEL_EXT)
            trig[c] = ctrl[c][CTRL_EDGE] ? (ext_s2[c] & !ext_s3[c])
                                         : (!ext_s2[c] & ext_s3[c]);
         else if (32'(f) <= NPERIPH)
            trig[c] = periph_irq_i[32'(f) - 1];
         else
            trig[c] = 1'b0;
      end
   end

   // a set in the same cycle as any clear wins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         req <= 2'h0;
      else
         for (int c = 0; c < 2; c++)
         begin
            if ((start && pick == c[0])
                || (ctrl_wr[c] && wb_sel_i[0] && !wb_dat_i[CTRL_REQ]))
               req[c] <= 1'b0;
            if (trig[c])
               req[c] <= 1'b1;
         end
   end

   // ---------------- enable, restart and reloads
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en    <= 2'h0;
         first <= 2'h0;
      end
      else
         for (int c = 0; c < 2; c++)
         begin
            if (start && pick == c[0])
               first[c] <= 1'b0;
            if (finish && cur == c[0] && cnt_lat == CNT_W'(1))
               en[c] <= 1'b0;
            if (ctrl_wr[c] && wb_sel_i[0])
            begin
               if (wb_dat_i[CTRL_EN])
               begin
                  en[c]    <= 1'b1;
                  first[c] <= 1'b1;
               end
               else
                  en[c] <= 1'b0;
            end
         end
   end

   always_comb
   begin
      for (int c = 0; c < 2; c++)
         fwd_base[c] = first[c] ? (ctrl[c][CTRL_DIR] ? dst[c] : src[c])
                                : fwd[c];
   end

   // channel zero wins any tie
   assign pick_any = (en[0] & req[0]) | (en[1] & req[1]);
   assign pick     = !(en[0] & req[0]);
   assign start    = (state == S_IDLE) & pick_any & bus_grant_i;
   assign last_beat = (state == S_RD) ? (beat == rd_n[1])
                                      : (beat == wr_n[1]);
   assign finish   = (state == S_WR) & mem_valid_o & mem_ack_i & last_beat;
   assign bus_req_o = ((state == S_IDLE) & pick_any)
                      | (state == S_RD) | (state == S_WR);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state     <= S_IDLE;
         cur       <= 1'b0;
         rd_base   <= '0;
         wr_base   <= '0;
         fwd_lat   <= '0;
         cnt_lat   <= '0;
         unit_byte <= 1'b0;
         dir_lat   <= 1'b0;
         rd_n      <= BEATS_ONE;
         wr_n      <= BEATS_ONE;
      end
      else
         case (state)
            S_IDLE:
               if (start)
               begin
                  state     <= S_RD;
                  cur       <= pick;
                  fwd_lat   <= fwd_base[pick];
                  cnt_lat   <= first[pick] ? reload[pick]
                                           : count[pick];
                  dir_lat   <= ctrl[pick][CTRL_DIR];
                  unit_byte <= ctrl[pick][CTRL_UNIT];
                  rd_base   <= ctrl[pick][CTRL_DIR] ? src[pick]
                                                    : fwd_base[pick];
                  wr_base   <= ctrl[pick][CTRL_DIR] ? fwd_base[pick]
                                                    : dst[pick];
                  // beat counts fixed at start, the first issue needs them
                  rd_n      <= beats(ctrl[pick][CTRL_UNIT], byte_bus,
                                     ctrl[pick][CTRL_DIR] ? src[pick][0]
                                     : fwd_base[pick][0]);
                  wr_n      <= beats(ctrl[pick][CTRL_UNIT], byte_bus,
                                     ctrl[pick][CTRL_DIR] ? fwd_base[pick][0]
                                     : dst[pick][0]);
               end
            S_RD:
               if (mem_valid_o && mem_ack_i && last_beat)
                  state <= S_WR;
            S_WR:
               if (finish)
                  state <= S_CPU;
            S_CPU:
               if (cpu_done_i)
                  state <= S_IDLE;
            default:
               state <= S_IDLE;
         endcase
   end

   // one beat in flight at a time; the next waits for the previous ack
   assign issue = !mem_valid_o && (((state == S_RD) && buf_in_ready)
                  || ((state == S_WR) && buf_out_valid));

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mem_valid_o <= 1'b0;
         mem_req_o   <= '0;
         beat        <= 1'b0;
         lo_byte     <= 8'h00;
      end
      else
      begin
         if (issue)
         begin
            mem_valid_o       <= 1'b1;
            mem_req_o.we      <= (state == S_WR);
            mem_req_o.addr    <= ((state == S_RD) ? rd_base : wr_base)
                                 + ADDR_W'(beat);
            mem_req_o.byte_sz <= unit_byte
                                 | (beat ? 1'b1 : ((state == S_RD)
                                    ? rd_n[1] : wr_n[1]));
            mem_req_o.wdata   <= beat ? {8'h00, buf_out_data[15:8]}
                                      : buf_out_data;
         end
         if (mem_valid_o && mem_ack_i)
         begin
            mem_valid_o <= 1'b0;
            beat        <= last_beat ? 1'b0 : 1'b1;
            if (state == S_RD && !beat)
               lo_byte <= mem_rdata_i[7:0];
         end
      end
   end

   assign buf_in_valid = (state == S_RD) & mem_valid_o & mem_ack_i
                         & last_beat;
   assign buf_in_data  = beat ? {mem_rdata_i[7:0], lo_byte} : mem_rdata_i;

   dcc_buf2 #(
      .W     (DATA_W),
      .DEPTH (2)
   ) u_buf (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (buf_in_valid),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (buf_in_data),
      .out_valid_o (buf_out_valid),
      .out_ready_i (finish),
      .out_data_o  (buf_out_data)
   );

   // ---------------- completion: pointer, counter, cycle accounting
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         for (int c = 0; c < 2; c++)
         begin
            count[c]  <= '0;
            fwd[c]    <= '0;
            cycles[c] <= 8'h00;
         end
      else if (finish)
      begin
         count[cur]  <= cnt_lat - 1'b1;
         fwd[cur]    <= fwd_lat + (unit_byte ? ADDR_W'(1) : ADDR_W'(2));
         cycles[cur] <= 8'(rd_n) * 8'(coef(rd_base, cfg))
                        + 8'(wr_n) * 8'(coef(wr_base, cfg));
      end
   end

   // ---------------- checks
   sequence s_start_first(c);
      start && pick == c && first[c];
   endsequence

   sequence s_finish;
      finish;
   endsequence

   a_req_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      trig[0] |=> req[0])
      else $error("request bit did not set on its factor");

   a_req_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      start && !pick && !trig[0] |=> !req[0] && state == S_RD)
      else $error("request bit not cleared at transfer start");

   a_sw_one_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_wr[1] && wb_sel_i[0] && wb_dat_i[CTRL_REQ] && !req[1] && !trig[1]
      |=> !req[1])
      else $error("software set a request bit");

   a_enable_restart: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_wr[0] && wb_sel_i[0] && wb_dat_i[CTRL_EN] |=> en[0] && first[0])
      else $error("enable write did not arm a restart");

   a_fwd_reload: assert property (@(posedge clk_i) disable iff (rst_i)
      s_start_first(1'b0) |=> fwd_lat == ($past(ctrl[0][CTRL_DIR])
                                ? $past(dst[0]) : $past(src[0])))
      else $error("forward pointer not reloaded");

   a_count_reload: assert property (@(posedge clk_i) disable iff (rst_i)
      s_start_first(1'b1) |=> cnt_lat == $past(reload[1]))
      else $error("transfer counter not reloaded");

   a_zero_first: assert property (@(posedge clk_i) disable iff (rst_i)
      start && en[0] && req[0] && en[1] && req[1] |=> !cur ##0 req[1])
      else $error("channel one served before channel zero");

   a_cpu_slot: assert property (@(posedge clk_i) disable iff (rst_i)
      s_finish |=> state == S_CPU && !bus_req_o)
      else $error("bus not handed back after a transfer");

   a_split_word: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_RD && issue && !unit_byte && byte_bus |=> mem_req_o.byte_sz)
      else $error("word on byte bus not split");

   a_cycle_sum: assert property (@(posedge clk_i) disable iff (rst_i)
      s_finish ##0 (!unit_byte && rd_n == BEATS_TWO && wr_n == BEATS_TWO
                    && rd_base < INT_LIMIT && wr_base < INT_LIMIT
                    && cfg[CFG_INT_WAIT])
      |=> cycles[$past(cur)] == 8'h08)
      else $error("cycle count wrong");
endmodule

// ==== dcc_mem_model.sv ====
// far-side model: arbiter, cpu slot and memory for the dma controller
`timescale 1ns/1ns
module dcc_mem_model
   import dcc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              slow_i,
   input  wire logic              bus_req_i,
   output logic                   bus_grant_o,
   output logic                   cpu_done_o,
   input  wire dcc_mem_req_t      mem_req_i,
   input  wire logic              mem_valid_i,
   output logic                   mem_ack_o,
   output logic [DATA_W-1:0]      mem_rdata_o
);
   logic [7:0] m [256];
   logic [1:0] wt;
   logic [7:0] a;
   assign a = mem_req_i.addr[7:0];
   initial
   begin
      for (int i = 0; i < 256; i++)
         m[i] = 8'(i) ^ 8'h5A;
   end
   // cpu takes its one access while the controller leaves the bus
   always @(posedge clk_i)
   begin
      bus_grant_o <= !rst_i;
      cpu_done_o <= !rst_i && !bus_req_i && !cpu_done_o;
   end
   // slow mode stretches each beat; read data goes stale outside ack
   always @(posedge clk_i)
   begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (rst_i)
      begin
         wt <= 2'h0;
         mem_rdata_o <= 16'h0000;
      end
      else if (mem_valid_i && !mem_ack_o)
      begin
         if (wt != (slow_i ? 2'h3 : 2'h0))
            wt <= wt + 2'h1;
         else
         begin
            wt <= 2'h0;
            mem_ack_o <= 1'b1;
            if (mem_req_i.we)
            begin
               m[a] <= mem_req_i.wdata[7:0];
               if (!mem_req_i.byte_sz)
                  m[a + 8'h01] <= mem_req_i.wdata[15:8];
            end
            else if (mem_req_i.byte_sz)
               mem_rdata_o <= {~m[a], m[a]};
            else
               mem_rdata_o <= {m[a + 8'h01], m[a]};
         end
      end
   end
endmodule

// ==== dcc_dma_ctrl_bench.sv ====
// self-checking bench of the two-channel dma controller
`timescale 1ns/1ns
module dcc_dma_ctrl_bench
   import dcc_pkg::*;
   ;
   logic               clk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic               cyc = 1'b0;
   logic               stb = 1'b0;
   logic               we = 1'b0;
   logic [7:0]         adr = 8'h00;
   logic [31:0]        dat = 32'h0;
   logic [31:0]        dat_o;
   logic [31:0]        rd_dat;
   logic               ack;
   logic [NPERIPH-1:0] irq = '0;
   logic [1:0]         pin = 2'h0;
   logic               bbus = 1'b0;
   logic               slow = 1'b0;
   logic               breq;
   logic               gnt;
   logic               cdone;
   dcc_mem_req_t       mreq;
   logic               mvalid;
   logic               mack;
   logic [DATA_W-1:0]  mrdata;
   logic [ADDR_W-1:0]  wq [$];
   int                 n_fail = 0;
   int                 checked = 0;
   always #25 clk_i = ~clk_i;
   dcc_dma_ctrl u_dcc_dma_ctrl (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .periph_irq_i(irq), .external_request_pin_i(pin),
      .byte_bus_pin_i(bbus), .bus_req_o(breq), .bus_grant_i(gnt),
      .cpu_done_i(cdone), .mem_req_o(mreq), .mem_valid_o(mvalid),
      .mem_ack_i(mack), .mem_rdata_i(mrdata));
   dcc_mem_model u_dcc_mem_model (.clk_i(clk_i), .rst_i(rst_i),
      .slow_i(slow), .bus_req_i(breq), .bus_grant_o(gnt),
      .cpu_done_o(cdone), .mem_req_i(mreq), .mem_valid_i(mvalid),
      .mem_ack_o(mack), .mem_rdata_o(mrdata));
   always @(posedge clk_i)
      if (mvalid && mack && mreq.we)
         wq.push_back(mreq.addr);
   task automatic wrap_up();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic hang(input string nm);
      n_fail++;
      $display("BAD %s exp done got timeout", nm);
      wrap_up();
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // one classic cycle; ack is taken at the edge that samples it
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      i = 0;
      do
      begin
         @(posedge clk_i);
         i++;
      end
      while (ack !== 1'b1 && i < 20);
      rd_dat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i >= 20)
         hang("wb ack");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, e, rd_dat);
   endtask
   task automatic wait_xfer();
      int i;
      for (i = 0; i < 100 && mvalid !== 1'b1; i++)
         @(posedge clk_i);
      for (i = 0; i < 300 && breq !== 1'b0; i++)
         @(posedge clk_i);
      if (i >= 300)
         hang("transfer");
      repeat (4) @(posedge clk_i);
   endtask
   initial
   begin
      #1000000;
      hang("run");
   end
   initial
   begin
      int i;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFF_CTRL, 32'h0, "ctrl0 reset");
      rd(8'h80, 32'h0, "unmapped");
      wb(1'b1, OFF_SRC, 32'h1000);
      wb(1'b1, OFF_DST, 32'h1010);
      wb(1'b1, OFF_RELOAD, 32'h2);
      wb(1'b1, OFF_CTRL, 32'h21);
      wait_xfer();
      rd(OFF_COUNT, 32'h1, "count");
      rd(OFF_FWD, 32'h1002, "fwd");
      rd(OFF_CYCLES, 32'h2, "cycles");
      chk("dst lo", 32'h5A, u_dcc_mem_model.m[8'h10]);
      chk("dst hi", 32'h5B, u_dcc_mem_model.m[8'h11]);
      $display("test word transfer done");
      bbus <= 1'b1;
      slow <= 1'b1;
      wb(1'b1, OFF_CFG, 32'h1);
      wb(1'b1, OFF_SRC, 32'h1001);
      wb(1'b1, OFF_DST, 32'h1020);
      wb(1'b1, OFF_CTRL, 32'h21);
      wait_xfer();
      rd(OFF_COUNT, 32'h1, "count again");
      rd(OFF_FWD, 32'h1003, "fwd odd");
      rd(OFF_CYCLES, 32'h8, "cycles byte bus");
      chk("odd lo", 32'h5B, u_dcc_mem_model.m[8'h20]);
      chk("odd hi", 32'h58, u_dcc_mem_model.m[8'h21]);
      bbus <= 1'b0;
      slow <= 1'b0;
      wb(1'b1, OFF_CFG, 32'h0);
      $display("test restart done");
      wb(1'b1, CH_STRIDE + OFF_CTRL, 32'hF10);
      wb(1'b1, CH_STRIDE + OFF_CTRL, 32'hF10);
      @(posedge clk_i);
      pin <= 2'h2;
      repeat (4) @(posedge clk_i);
      pin <= 2'h0;
      rd(CH_STRIDE + OFF_CTRL, 32'hF12, "ext req");
      wb(1'b1, CH_STRIDE + OFF_CTRL, 32'hF12);
      rd(CH_STRIDE + OFF_CTRL, 32'hF12, "req write one");
      wb(1'b1, CH_STRIDE + OFF_CTRL, 32'h310);
      wb(1'b1, CH_STRIDE + OFF_CTRL, 32'h310);
      rd(CH_STRIDE + OFF_CTRL, 32'h310, "req write zero");
      wb(1'b1, CH_STRIDE + OFF_CTRL, 32'h312);
      rd(CH_STRIDE + OFF_CTRL, 32'h310, "req sw one");
      @(posedge clk_i);
      irq <= 14'h0004;
      @(posedge clk_i);
      irq <= '0;
      rd(CH_STRIDE + OFF_CTRL, 32'h312, "periph req");
      $display("test request bits done");
      wb(1'b1, OFF_CTRL, 32'h100);
      wb(1'b1, OFF_CTRL, 32'h100);
      wb(1'b1, CH_STRIDE + OFF_CTRL, 32'h100);
      wb(1'b1, CH_STRIDE + OFF_CTRL, 32'h100);
      wb(1'b1, OFF_DST, 32'h1030);
      wb(1'b1, CH_STRIDE + OFF_SRC, 32'h1000);
      wb(1'b1, CH_STRIDE + OFF_DST, 32'h1040);
      wb(1'b1, CH_STRIDE + OFF_RELOAD, 32'h2);
      wb(1'b1, OFF_CTRL, 32'h101);
      wb(1'b1, CH_STRIDE + OFF_CTRL, 32'h101);
      wq.delete();
      @(posedge clk_i);
      irq <= 14'h0001;
      @(posedge clk_i);
      irq <= '0;
      for (i = 0; i < 400 && wq.size() < 2; i++)
         @(posedge clk_i);
      if (wq.size() < 2)
         hang("both channels");
      chk("first write", 32'h1030, {12'h0, wq[0]});
      chk("second write", 32'h1040, {12'h0, wq[1]});
      $display("test priority done");
      wrap_up();
   end
endmodule
